/* bench/dbl_dev_model.sv */
// behavioural model of the double-buffered converter latches
`timescale 1ns/10ps
`default_nettype none
module dbl_dev_model (
    input wire dbl_pkg::dbl_pins_t i_pins,
    input wire logic [15:0] i_bus,
    output logic [15:0] o_code
);
    logic cs;
    logic ub;
    logic lb;
    logic ld;
    logic [7:0] upper;
    logic [7:0] lower;
    // all controls are active low levels
    assign cs = ~i_pins.chip_select_n;
    assign ub = ~i_pins.upper_byte_load_n;
    assign lb = ~i_pins.lower_byte_load_n;
    assign ld = ~i_pins.output_register_load_n;
    // first rank: open only while selected, else holds
    always_latch begin
        if (cs && ub) begin
            upper <= i_bus[15:8];
        end
    end
    always_latch begin
        if (cs && lb) begin
            lower <= i_bus[7:0];
        end
    end
    // code is offset binary: zero is minus, all ones plus reference
    always_latch begin
        if (cs && ld) begin
            o_code <= {upper, lower};
        end
    end
endmodule
`default_nettype wire

/* bench/dbl_host_test.sv */
// self-checking bench for the converter latch host
`timescale 1ns/10ps
`default_nettype none
module dbl_host_test;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req = 1'b0;
    logic [15:0] i_word = 16'h0000;
    dbl_pkg::dbl_mode_t i_mode = dbl_pkg::dbl_mode_word;
    logic i_low_first = 1'b0;
    logic o_busy;
    logic o_done;
    logic [7:0] o_data;
    dbl_pkg::dbl_pins_t o_pins;
    logic [15:0] bus;
    logic [15:0] code;
    logic [15:0] prev;
    int miscompares = 0;
    int cmp_count = 0;
    int n_chg = 0;
    dbl_host i_dbl_host (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_req(i_req), .i_word(i_word), .i_mode(i_mode),
        .i_low_first(i_low_first), .o_busy(o_busy), .o_done(o_done),
        .o_data(o_data), .o_pins(o_pins));
    dbl_dev_model i_dbl_dev_model (.i_pins(o_pins), .i_bus(bus),
        .o_code(code));
    // word mode: low lane wired from the word source, host drives upper
    assign bus = (i_mode == dbl_pkg::dbl_mode_word) ?
        {o_data, i_word[7:0]} : {o_data, o_data};
    always #2 i_clk_sys = ~i_clk_sys;
    // counts settled output steps once per cycle; zero-time latch ripple
    // between the two ranks is not a half-built word
    logic [15:0] code_q;
    always @(negedge i_clk_sys) begin
        if (code !== code_q) begin
            n_chg = n_chg + 1;
        end
        code_q = code;
    end
    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
        cmp_count++;
    endtask
    task automatic summarize;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one word transfer, then the output must step once to the word, or not at all if it already holds it
    task automatic run(input logic [15:0] w, input dbl_pkg::dbl_mode_t m,
            input logic lf);
        int k;
        prev = code;
        @(posedge i_clk_sys);
        i_word <= w;
        i_mode <= m;
        i_low_first <= lf;
        i_req <= 1'b1;
        n_chg = 0;
        @(posedge i_clk_sys);
        i_req <= 1'b0;
        repeat (3) @(negedge i_clk_sys);
        check("busy", {15'h0000, o_busy}, 16'h0001);
        k = 0;
        while (o_done !== 1'b1 && k < 1000) begin
            @(negedge i_clk_sys);
            k++;
        end
        check("done", {15'h0000, o_done}, 16'h0001);
        check("code", code, w);
        check("steps", n_chg[15:0], (w !== prev) ? 16'h0001 : 16'h0000);
    endtask
    task automatic t_reset_idle;
        @(negedge i_clk_sys);
        check("pins_rst", {12'h000, o_pins}, 16'h000f);
        check("data_rst", {8'h00, o_data}, 16'h0000);
        check("flags_rst", {14'h0000, o_busy, o_done}, 16'h0000);
    endtask
    task automatic t_word;
        run(16'h0000, dbl_pkg::dbl_mode_word, 1'b0);
        run(16'hffff, dbl_pkg::dbl_mode_word, 1'b0);
        run(16'h8001, dbl_pkg::dbl_mode_word, 1'b1);
    endtask
    task automatic t_sync;
        run(16'h8000, dbl_pkg::dbl_mode_sync, 1'b0);
        run(16'h7fff, dbl_pkg::dbl_mode_sync, 1'b1);
    endtask
    task automatic t_third;
        run(16'ha55a, dbl_pkg::dbl_mode_third, 1'b1);
        run(16'h5aa5, dbl_pkg::dbl_mode_third, 1'b0);
        run(16'h5aa5, dbl_pkg::dbl_mode_third, 1'b0);
    endtask
    // second request while busy is ignored, output keeps first word
    task automatic t_refused;
        int k;
        @(posedge i_clk_sys);
        i_word <= 16'h1234;
        i_mode <= dbl_pkg::dbl_mode_sync;
        i_req <= 1'b1;
        @(posedge i_clk_sys);
        i_req <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_word <= 16'hedcb;
        i_req <= 1'b1;
        @(posedge i_clk_sys);
        i_req <= 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 1000) begin
            @(negedge i_clk_sys);
            k++;
        end
        k = 0;
        repeat (300) begin
            @(negedge i_clk_sys);
            k = k + ((o_done === 1'b1) ? 1 : 0);
        end
        check("no_second", k[15:0], 16'h0000);
        check("code_kept", code, 16'h1234);
    endtask
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        t_reset_idle();
        repeat (5) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        t_word();
        t_sync();
        t_third();
        t_refused();
        summarize();
    end
endmodule
`default_nettype wire

/* hdl/dbl_defs.svh */
// timing counts and field positions for the converter latch host
`ifndef DBL_DEFS_SVH
`define DBL_DEFS_SVH
`define DBL_BYTE_W 8
`define DBL_WORD_W 16
`define DBL_HI_LSB 8
`define DBL_STROBE_NS 70
`define DBL_SETUP_NS 60
`define DBL_HOLD_NS 20
`define DBL_CLK_NS 4
`define DBL_STROBE_CYC ((`DBL_STROBE_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_SETUP_CYC ((`DBL_SETUP_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_HOLD_CYC ((`DBL_HOLD_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_PINS_IDLE 4'hf
`endif

/* hdl/dbl_host.sv */
// host that writes 16-bit words into the double-buffered converter latches
`timescale 1ns/10ps
`include "dbl_defs.svh"
`default_nettype none
module dbl_host #(
    parameter int STROBE_CYC = `DBL_STROBE_CYC,
    parameter int SETUP_CYC = `DBL_SETUP_CYC,
    parameter int HOLD_CYC = `DBL_HOLD_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic [15:0] i_word,
    input wire dbl_pkg::dbl_mode_t i_mode,
    input wire logic i_low_first,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_data,
    output dbl_pkg::dbl_pins_t o_pins
);
    dbl_pkg::dbl_state_t state;
    dbl_pkg::dbl_state_t next_state;
    dbl_pkg::dbl_mode_t mode;
    dbl_pkg::dbl_mode_t next_mode;
    dbl_pkg::dbl_pins_t next_pins;
    logic [15:0] word;
    logic [15:0] next_word;
    logic [1:0] step;
    logic [1:0] next_step;
    logic low_first;
    logic next_low_first;
    logic [7:0] next_data;
    logic next_busy;
    logic next_done;
    logic t_load;
    logic [5:0] t_count;
    logic t_done;
    logic upper_now;
    logic last_step;

    dbl_timer #(.W(6)) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_load(t_load),
        .i_count(t_count),
        .o_done(t_done)
    );

    // which byte this step carries; word mode puts full word on one strobe
    always_comb begin
        upper_now = (step == 2'h0) ? !low_first : low_first;
        last_step = (mode == dbl_pkg::dbl_mode_word) ? 1'b1 :
                    (mode == dbl_pkg::dbl_mode_third) ? (step == 2'h2) :
                    (step == 2'h1);
    end

    // sequencer: setup, strobe, hold per cycle; pins idle high between, except word mode holds load low from setup until idle
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_word = word;
        next_step = step;
        next_low_first = low_first;
        next_pins = o_pins;
        next_data = o_data;
        next_busy = o_busy;
        next_done = 1'b0;
        t_load = 1'b0;
        t_count = 6'h00;
        case (state)
            dbl_pkg::dbl_idle: begin
                next_pins = `DBL_PINS_IDLE;
                if (i_req) begin
                    next_mode = i_mode;
                    next_word = i_word;
                    next_low_first = i_low_first;
                    next_step = 2'h0;
                    next_busy = 1'b1;
                    next_state = dbl_pkg::dbl_setup;
                end
            end
            dbl_pkg::dbl_setup: begin
                // present data first, byte enables drop with the strobe later
                next_pins.chip_select_n = 1'b1;
                next_pins.upper_byte_load_n = 1'b1;
                next_pins.lower_byte_load_n = 1'b1;
                next_pins.output_register_load_n =
                    (mode != dbl_pkg::dbl_mode_word);
                if (step == 2'h2) begin
                    next_data = o_data;
                // word mode: host carries the upper lane whatever the order
                end else if (upper_now || mode == dbl_pkg::dbl_mode_word) begin
                    next_data = word[15:8];
                end else begin
                    next_data = word[7:0];
                end
                t_load = 1'b1;
                t_count = 6'(SETUP_CYC);
                next_state = dbl_pkg::dbl_strobe;
            end
            dbl_pkg::dbl_strobe: begin
                if (t_done && next_pins.chip_select_n) begin
                    // strobe edge: select low opens the chosen latch
                    next_pins.chip_select_n = 1'b0;
                    if (mode == dbl_pkg::dbl_mode_word) begin
                        next_pins.upper_byte_load_n = 1'b0;
                        next_pins.lower_byte_load_n = 1'b0;
                    end else if (step == 2'h2) begin
                        next_pins.output_register_load_n = 1'b0;
                    end else begin
                        next_pins.upper_byte_load_n = !upper_now;
                        next_pins.lower_byte_load_n = upper_now;
                        if (mode == dbl_pkg::dbl_mode_sync && last_step) begin
                            next_pins.output_register_load_n = 1'b0;
                        end
                    end
                    t_load = 1'b1;
                    t_count = 6'(STROBE_CYC);
                end else if (t_done && !o_pins.chip_select_n) begin
                    next_pins = `DBL_PINS_IDLE;
                    if (mode == dbl_pkg::dbl_mode_word) begin
                        next_pins.output_register_load_n = 1'b0;
                    end
                    t_load = 1'b1;
                    t_count = 6'(HOLD_CYC);
                    next_state = dbl_pkg::dbl_hold;
                end
            end
            dbl_pkg::dbl_hold: begin
                if (t_done) begin
                    next_state = dbl_pkg::dbl_next;
                end
            end
            default: begin
                if (last_step) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = dbl_pkg::dbl_idle;
                end else begin
                    next_step = step + 2'h1;
                    next_state = dbl_pkg::dbl_setup;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= dbl_pkg::dbl_idle;
            mode <= dbl_pkg::dbl_mode_word;
            word <= 16'h0000;
            step <= 2'h0;
            low_first <= 1'b0;
            o_pins <= `DBL_PINS_IDLE;
            o_data <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            word <= next_word;
            step <= next_step;
            low_first <= next_low_first;
            o_pins <= next_pins;
            o_data <= next_data;
            o_busy <= next_busy;
            o_done <= next_done;
        end
    end

    // data stays put while any latch is open
    a_data_stable: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !o_pins.chip_select_n && !$fell(o_pins.chip_select_n)
        |-> $stable(o_data))
        else $error("data moved during strobe");
    // never both byte enables low in byte modes
    a_one_byte: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        mode != dbl_pkg::dbl_mode_word |->
        !(!o_pins.upper_byte_load_n && !o_pins.lower_byte_load_n))
        else $error("both byte enables low in byte mode");
    // enables only low with select low
    a_sel_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_pins.chip_select_n |-> o_pins.upper_byte_load_n
        && o_pins.lower_byte_load_n)
        else $error("byte enable low without select");
    // strobe lasts at least eight cycles and then ends
    a_strobe_len: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(o_pins.chip_select_n) |->
        !o_pins.chip_select_n [*8] ##[1:20] o_pins.chip_select_n)
        else $error("strobe too short");
    // run length of select low; saturates so a stuck strobe cannot wrap
    logic [5:0] low_len;
    logic [5:0] next_low_len;
    always_comb begin
        next_low_len = 6'h00;
        if (!o_pins.chip_select_n) begin
            next_low_len = (low_len == 6'h3f) ? low_len : low_len + 6'h01;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_len <= 6'h00;
        end else begin
            low_len <= next_low_len;
        end
    end
    // select strobe is exactly the programmed number of cycles
    a_strobe_exact: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_pins.chip_select_n) |-> low_len == 6'(STROBE_CYC))
        else $error("strobe length differs from setting");
    // idle pins all high
    a_idle_pins: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        state == dbl_pkg::dbl_idle && $past(state) == dbl_pkg::dbl_idle
        |-> o_pins == `DBL_PINS_IDLE)
        else $error("pins not idle");
    // done rises in the same cycle that busy clears
    a_done_end: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_done |-> !o_busy && $past(o_busy))
        else $error("done without end of cycle");
    // third mode: load strobe alone
    a_third_load: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        mode == dbl_pkg::dbl_mode_third && !o_pins.output_register_load_n
        |-> o_pins.upper_byte_load_n && o_pins.lower_byte_load_n)
        else $error("load with byte enable in third mode");
    // sync mode load only with a byte enable
    a_sync_load: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        mode == dbl_pkg::dbl_mode_sync && !o_pins.output_register_load_n
        |-> !(o_pins.upper_byte_load_n && o_pins.lower_byte_load_n))
        else $error("sync load without byte enable");
endmodule
`default_nettype wire

/* hdl/dbl_pkg.sv */
// types for the converter latch host
`default_nettype none
package dbl_pkg;
    typedef enum logic [1:0] {
        dbl_mode_word,
        dbl_mode_sync,
        dbl_mode_third
    } dbl_mode_t;
    typedef struct packed {
        logic chip_select_n;
        logic upper_byte_load_n;
        logic lower_byte_load_n;
        logic output_register_load_n;
    } dbl_pins_t;
    typedef enum logic [2:0] {
        dbl_idle,
        dbl_setup,
        dbl_strobe,
        dbl_hold,
        dbl_next
    } dbl_state_t;
endpackage
`default_nettype wire

/* hdl/dbl_timer.sv */
// down counter that paces phases of a bus cycle
`timescale 1ns/10ps
`default_nettype none
module dbl_timer #(
    parameter int W = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    // load wins over counting; done when at one or zero
    always_comb begin
        next_cnt = cnt;
        if (i_load) begin
            next_cnt = i_count;
        end else if (cnt != '0) begin
            next_cnt = cnt - W'(1);
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
    // done must not look at the load: the sequencer loads on done
    assign o_done = (cnt <= W'(1));
endmodule
`default_nettype wire
